//--- verilog/ata_task_file_udma_port.sv
// Task-file register port with PIO and Ultra DMA data paths, device side.
// Assumes host pins are asynchronous to clk_sys; the host data-out strobe
// arrives on hstrobe_clk and is the only clock of the capture rings.
module ata_task_file_udma_port #(
   parameter int RING_AW = 3,
   parameter int ROOM_MIN = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic hstrobe_clk,
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic diow_n,
   input wire logic dmack_n,
   input wire logic [15:0] dd_in,
   output logic [15:0] dd_out,
   output logic dd_oe_n,
   output logic dmarq,
   output logic iordy_out,
   output logic iordy_oe_n,
   output logic intrq,
   input wire logic dev_pos,
   input wire logic true_ide_mode,
   input wire logic sleep_mode,
   input wire logic [7:0] status_in,
   input wire logic [7:0] fault_in,
   input wire logic irq_req,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output ata_port_pkg::cmd_kind_e cmd_kind,
   output logic [7:0] cmd_option,
   output logic [7:0] cmd_count,
   output logic [23:0] cmd_lba,
   output logic [7:0] cmd_target,
   output logic soft_reset,
   input wire logic [15:0] pio_rd_word,
   output logic pio_rd_take,
   output logic [15:0] pio_wr_word,
   output logic pio_wr_valid,
   input wire logic udma_in_req,
   input wire logic [15:0] din_word,
   input wire logic din_valid,
   output logic din_take,
   input wire logic udma_out_req,
   output logic [15:0] dout_word,
   output logic dout_valid,
   output logic burst_active
);
   localparam int PW = RING_AW + 1;
   localparam int DEPTH = 1 << RING_AW;
   typedef struct packed {
      ata_port_pkg::pins_s p1;
      ata_port_pkg::pins_s p2;
      logic [2*PW-1:0] g1;
      logic [2*PW-1:0] g2;
      logic rd_prev;
      logic wr_prev;
      logic [15:0] wdat;
      logic strap;
      logic [7:0] option;
      logic [7:0] length;
      logic [7:0] addr_low;
      logic [7:0] addr_mid;
      logic [7:0] addr_high;
      logic [7:0] target;
      logic irq_off;
      logic srst;
      logic cmd_valid;
      logic [7:0] cmd_code;
      ata_port_pkg::cmd_kind_e cmd_kind;
      logic [7:0] cmd_option;
      logic [7:0] cmd_count;
      logic [23:0] cmd_lba;
      logic [7:0] cmd_target;
      logic [15:0] rd;
      logic oe;
      logic pio_take;
      logic [15:0] pio_wr_word;
      logic pio_wr_valid;
      logic intrq;
      ata_port_pkg::burst_e st;
      logic dmarq;
      logic ready;
      logic dstrobe;
      logic phase;
      logic pend;
      logic stop_armed;
      logic [7:0] rp_cnt;
      logic [PW-1:0] rise_rp;
      logic [PW-1:0] fall_rp;
      logic next_fall;
      logic [15:0] dout;
      logic dout_valid;
      logic din_take;
      logic out_dir;
   } state_s;
   state_s s_q;
   state_s s_d;
   function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction
   function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
      return b ^ (b >> 1);
   endfunction
   function automatic ata_port_pkg::cmd_kind_e decode(input logic [7:0] op);
      case (op)
         ata_port_pkg::OP_POWER_CHECK_A, ata_port_pkg::OP_POWER_CHECK_B: begin
            return ata_port_pkg::CMD_POWER_CHECK;
         end
         ata_port_pkg::OP_DIAGNOSTIC: return ata_port_pkg::CMD_DIAGNOSTIC;
         ata_port_pkg::OP_ERASE: return ata_port_pkg::CMD_ERASE;
         ata_port_pkg::OP_FORMAT: return ata_port_pkg::CMD_FORMAT;
         ata_port_pkg::OP_IDENTIFY: return ata_port_pkg::CMD_IDENTIFY;
         ata_port_pkg::OP_IDLE_A, ata_port_pkg::OP_IDLE_B: begin
            return ata_port_pkg::CMD_IDLE;
         end
         ata_port_pkg::OP_IDLE_NOW_A, ata_port_pkg::OP_IDLE_NOW_B: begin
            return ata_port_pkg::CMD_IDLE_NOW;
         end
         default: return ata_port_pkg::CMD_UNKNOWN;
      endcase
   endfunction
   // Host strobe domain: two rings, one per strobe edge
   logic [PW-1:0] rise_wp_q;
   logic [PW-1:0] fall_wp_q;
   logic [PW-1:0] rise_wbin;
   logic [PW-1:0] fall_wbin;
   logic [15:0] rise_mem [DEPTH];
   logic [15:0] fall_mem [DEPTH];
   logic link_cap;
   assign rise_wbin = g2b(rise_wp_q);
   assign fall_wbin = g2b(fall_wp_q);
   // Out_dir and DMACK are static across a burst; the strobe may not run
   // before a burst, so a synchroniser here could not settle in time
   assign link_cap = s_q.out_dir & (true_ide_mode ? ~dmack_n : dmack_n);
   always_ff @(posedge hstrobe_clk or posedge rst) begin
      if (rst) begin
         rise_wp_q <= '0;
      end else if (link_cap) begin
         rise_wp_q <= b2g(rise_wbin + PW'(1));
      end
   end
   always_ff @(posedge hstrobe_clk) begin
      if (link_cap) begin
         rise_mem[rise_wbin[RING_AW-1:0]] <= dd_in;
      end
   end
   always_ff @(negedge hstrobe_clk or posedge rst) begin
      if (rst) begin
         fall_wp_q <= '0;
      end else if (link_cap) begin
         fall_wp_q <= b2g(fall_wbin + PW'(1));
      end
   end
   always_ff @(negedge hstrobe_clk) begin
      if (link_cap) begin
         fall_mem[fall_wbin[RING_AW-1:0]] <= dd_in;
      end
   end
   logic [PW-1:0] rise_seen;
   logic [PW-1:0] fall_seen;
   logic [PW-1:0] rise_occ;
   logic [PW-1:0] fall_occ;
   logic room_ok;
   logic dmack_act;
   logic cmd_blk;
   logic ctl_blk;
   logic selected;
   logic drq;
   logic rd_end;
   logic wr_end;
   logic stop;
   logic hdmardy;
   always_comb begin
      rise_seen = g2b(s_q.g2[2*PW-1:PW]);
      fall_seen = g2b(s_q.g2[PW-1:0]);
      rise_occ = rise_seen - s_q.rise_rp;
      fall_occ = fall_seen - s_q.fall_rp;
      // Headroom covers the three late words plus pointer sync lag
      room_ok = ({1'b0, rise_occ} + {1'b0, fall_occ}) <= (PW + 1)'(ROOM_MIN);
      dmack_act = s_q.p2.mode ? ~s_q.p2.dmack_n : s_q.p2.dmack_n;
      cmd_blk = s_q.p2.cs1_n & ~s_q.p2.cs0_n & ~dmack_act;
      ctl_blk = ~s_q.p2.cs1_n & s_q.p2.cs0_n & ~dmack_act
         & (s_q.p2.addr == ata_port_pkg::REG_CONTROL);
      selected = s_q.target[ata_port_pkg::TARGET_DEV_BIT] == s_q.strap;
      drq = status_in[ata_port_pkg::FLAGS_DRQ_BIT];
      rd_end = ~s_q.rd_prev & s_q.p2.rd_n;
      wr_end = ~s_q.wr_prev & s_q.p2.wr_n;
      stop = s_q.stop_armed & s_q.p2.wr_n;
      hdmardy = ~s_q.p2.rd_n;
      s_d = s_q;
      s_d.p1 = '{true_ide_mode, dev_pos, cs1_n, cs0_n, da, dior_n, diow_n, dmack_n, dd_in};
      s_d.p2 = s_q.p1;
      s_d.g1 = {rise_wp_q, fall_wp_q};
      s_d.g2 = s_q.g1;
      s_d.rd_prev = s_q.p2.rd_n;
      s_d.wr_prev = s_q.p2.wr_n;
      s_d.cmd_valid = 1'b0;
      s_d.pio_take = 1'b0;
      s_d.pio_wr_valid = 1'b0;
      s_d.dout_valid = 1'b0;
      s_d.din_take = 1'b0;
      s_d.strap = s_q.p2.strap; // Tracked: a one-shot grab saw the reset zeros
      if (!s_q.p2.wr_n) begin
         s_d.wdat = s_q.p2.data;
      end
      // Register writes; all devices latch the block, only command and data writes are gated
      if (wr_end && cmd_blk) begin
         case (s_q.p2.addr)
            ata_port_pkg::REG_DATA: begin
               if (drq) begin
                  s_d.pio_wr_word = s_q.wdat;
                  s_d.pio_wr_valid = selected;
               end
            end
            ata_port_pkg::REG_FAULT_OPTION: s_d.option = s_q.wdat[7:0];
            ata_port_pkg::REG_LENGTH: s_d.length = s_q.wdat[7:0];
            ata_port_pkg::REG_ADDR_LOW: s_d.addr_low = s_q.wdat[7:0];
            ata_port_pkg::REG_ADDR_MID: s_d.addr_mid = s_q.wdat[7:0];
            ata_port_pkg::REG_ADDR_HIGH: s_d.addr_high = s_q.wdat[7:0];
            ata_port_pkg::REG_TARGET: s_d.target = s_q.wdat[7:0];
            ata_port_pkg::REG_FLAGS_OPCODE: begin
               if (selected) begin
                  s_d.cmd_valid = 1'b1;
                  s_d.cmd_code = s_q.wdat[7:0];
                  s_d.cmd_kind = decode(s_q.wdat[7:0]);
                  s_d.cmd_option = s_q.option;
                  s_d.cmd_count = s_q.length;
                  s_d.cmd_lba = {s_q.addr_high, s_q.addr_mid, s_q.addr_low};
                  s_d.cmd_target = s_q.target;
               end
            end
            default: ;
         endcase
      end
      if (wr_end && ctl_blk) begin
         s_d.irq_off = s_q.wdat[ata_port_pkg::CONTROL_IRQ_OFF_BIT];
         s_d.srst = s_q.wdat[ata_port_pkg::CONTROL_SRST_BIT];
      end
      // Register reads, answered only by the selected device
      s_d.oe = 1'b0;
      if (!s_q.p2.rd_n && selected && (cmd_blk || ctl_blk)) begin
         s_d.oe = 1'b1;
         s_d.rd = {8'h00, status_in};
         if (cmd_blk) begin
            case (s_q.p2.addr)
               ata_port_pkg::REG_DATA: begin
                  // Sleep leaves the buffer undefined, so show zero
                  s_d.rd = (drq && !sleep_mode) ? pio_rd_word : '0;
               end
               ata_port_pkg::REG_FAULT_OPTION: s_d.rd = {8'h00, fault_in};
               ata_port_pkg::REG_LENGTH: s_d.rd = {8'h00, s_q.length};
               ata_port_pkg::REG_ADDR_LOW: s_d.rd = {8'h00, s_q.addr_low};
               ata_port_pkg::REG_ADDR_MID: s_d.rd = {8'h00, s_q.addr_mid};
               ata_port_pkg::REG_ADDR_HIGH: s_d.rd = {8'h00, s_q.addr_high};
               ata_port_pkg::REG_TARGET: s_d.rd = {8'h00, s_q.target};
               default: s_d.rd = {8'h00, status_in};
            endcase
         end
      end
      if (rd_end && cmd_blk && selected && drq && !sleep_mode
            && s_q.p2.addr == ata_port_pkg::REG_DATA) begin
         s_d.pio_take = 1'b1;
      end
      s_d.intrq = irq_req & ~s_q.irq_off & selected;
      // Drain host words in strobe order, one per cycle
      if (s_q.next_fall ? (fall_occ != '0) : (rise_occ != '0)) begin
         s_d.dout_valid = 1'b1;
         if (s_q.next_fall) begin
            s_d.dout = fall_mem[s_q.fall_rp[RING_AW-1:0]];
            s_d.fall_rp = s_q.fall_rp + PW'(1);
         end else begin
            s_d.dout = rise_mem[s_q.rise_rp[RING_AW-1:0]];
            s_d.rise_rp = s_q.rise_rp + PW'(1);
         end
         s_d.next_fall = ~s_q.next_fall;
      end
      if (!s_q.p2.wr_n && dmack_act) begin
         s_d.stop_armed = 1'b1;
      end
      case (s_q.st)
         ata_port_pkg::ST_IDLE: begin
            s_d.stop_armed = 1'b0;
            s_d.out_dir = 1'b0;
            s_d.dstrobe = 1'b0;
            s_d.pend = 1'b0;
            if (udma_in_req) begin
               s_d.dmarq = 1'b1;
               s_d.st = ata_port_pkg::ST_IN_RUN;
            end else if (udma_out_req) begin
               s_d.dmarq = 1'b1;
               s_d.out_dir = 1'b1;
               s_d.ready = 1'b0;
               s_d.st = ata_port_pkg::ST_OUT_RUN;
            end
         end
         ata_port_pkg::ST_IN_RUN: begin
            s_d.phase = ~s_q.phase;
            // Data set one cycle ahead of the strobe edge
            if (!s_q.phase && dmack_act && s_q.stop_armed && !stop
                  && hdmardy && din_valid && !s_q.pend) begin
               s_d.rd = din_word;
               s_d.din_take = 1'b1;
               s_d.pend = 1'b1;
            end
            if (s_q.phase && s_q.pend) begin
               s_d.dstrobe = ~s_q.dstrobe;
               s_d.pend = 1'b0;
            end
            if (stop || (!udma_in_req && !s_q.pend)) begin
               s_d.dmarq = 1'b0;
               s_d.st = ata_port_pkg::ST_IN_END;
            end
         end
         ata_port_pkg::ST_OUT_RUN: begin
            s_d.ready = dmack_act & room_ok & udma_out_req;
            if (stop || !udma_out_req) begin
               s_d.ready = 1'b0;
               s_d.rp_cnt = 8'(ata_port_pkg::T_RP_CYC);
               s_d.st = ata_port_pkg::ST_OUT_PAUSE;
            end
         end
         ata_port_pkg::ST_OUT_PAUSE: begin
            if (s_q.rp_cnt <= 8'h01) begin
               s_d.dmarq = 1'b0;
               s_d.st = ata_port_pkg::ST_OUT_END;
            end else begin
               s_d.rp_cnt = s_q.rp_cnt - 8'h01;
            end
         end
         ata_port_pkg::ST_IN_END, ata_port_pkg::ST_OUT_END: begin
            if (!dmack_act) begin
               s_d.st = ata_port_pkg::ST_IDLE;
            end
         end
         default: s_d.st = ata_port_pkg::ST_IDLE;
      endcase
      // Soft reset acts in any power state
      if (s_q.srst) begin
         s_d.option = ata_port_pkg::RESET_BYTE;
         s_d.length = ata_port_pkg::RESET_BYTE;
         s_d.addr_low = ata_port_pkg::RESET_BYTE;
         s_d.addr_mid = ata_port_pkg::RESET_BYTE;
         s_d.addr_high = ata_port_pkg::RESET_BYTE;
         s_d.target = ata_port_pkg::RESET_BYTE;
         s_d.cmd_valid = 1'b0;
         s_d.pio_wr_valid = 1'b0;
         s_d.din_take = 1'b0;
         s_d.dmarq = 1'b0;
         s_d.ready = 1'b0;
         s_d.out_dir = 1'b0;
         s_d.st = ata_port_pkg::ST_IDLE;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   logic in_burst;
   logic out_burst;
   assign in_burst = (s_q.st == ata_port_pkg::ST_IN_RUN) && dmack_act;
   assign out_burst = s_q.out_dir && dmack_act;
   assign dd_out = s_q.rd;
   assign dd_oe_n = ~(s_q.oe | in_burst);
   // Static strap read raw: its synced copy is zero just after reset
   assign dmarq = true_ide_mode ? s_q.dmarq : ~s_q.dmarq;
   // Device ready is active low on the wire; pin released outside bursts
   assign iordy_out = in_burst ? s_q.dstrobe : ~s_q.ready;
   assign iordy_oe_n = ~(in_burst | out_burst);
   assign intrq = s_q.intrq;
   assign cmd_valid = s_q.cmd_valid;
   assign cmd_code = s_q.cmd_code;
   assign cmd_kind = s_q.cmd_kind;
   assign cmd_option = s_q.cmd_option;
   assign cmd_count = s_q.cmd_count;
   assign cmd_lba = s_q.cmd_lba;
   assign cmd_target = s_q.cmd_target;
   assign soft_reset = s_q.srst;
   assign pio_rd_take = s_q.pio_take;
   assign pio_wr_word = s_q.pio_wr_word;
   assign pio_wr_valid = s_q.pio_wr_valid;
   assign din_take = s_q.din_take;
   assign dout_word = s_q.dout;
   assign dout_valid = s_q.dout_valid;
   assign burst_active = s_q.st != ata_port_pkg::ST_IDLE;

endmodule

//--- include/ata_port_pkg.sv
// Constants, encodings and shared types of the task-file and burst port.
// Assumes a 20 MHz system clock; figures in ns become cycles here.
package ata_port_pkg;

   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_FAULT_OPTION = 3'h1;
   localparam logic [2:0] REG_LENGTH = 3'h2;
   localparam logic [2:0] REG_ADDR_LOW = 3'h3;
   localparam logic [2:0] REG_ADDR_MID = 3'h4;
   localparam logic [2:0] REG_ADDR_HIGH = 3'h5;
   localparam logic [2:0] REG_TARGET = 3'h6;
   localparam logic [2:0] REG_FLAGS_OPCODE = 3'h7;
   localparam logic [2:0] REG_CONTROL = 3'h6;

   localparam int TARGET_DEV_BIT = 4;
   localparam int CONTROL_IRQ_OFF_BIT = 1;
   localparam int CONTROL_SRST_BIT = 2;
   localparam int FLAGS_DRQ_BIT = 3;
   localparam int FLAGS_ERR_BIT = 0;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   localparam logic [7:0] OP_POWER_CHECK_A = 8'h98;
   localparam logic [7:0] OP_POWER_CHECK_B = 8'he5;
   localparam logic [7:0] OP_DIAGNOSTIC = 8'h90;
   localparam logic [7:0] OP_ERASE = 8'hc0;
   localparam logic [7:0] OP_FORMAT = 8'h50;
   localparam logic [7:0] OP_IDENTIFY = 8'hec;
   localparam logic [7:0] OP_IDLE_A = 8'h97;
   localparam logic [7:0] OP_IDLE_B = 8'he3;
   localparam logic [7:0] OP_IDLE_NOW_A = 8'h95;
   localparam logic [7:0] OP_IDLE_NOW_B = 8'he1;

   localparam int CLK_PERIOD_NS = 50;
   localparam int T_RP_NS = 160;
   localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      CMD_UNKNOWN, CMD_POWER_CHECK, CMD_DIAGNOSTIC, CMD_ERASE,
      CMD_FORMAT, CMD_IDENTIFY, CMD_IDLE, CMD_IDLE_NOW
   } cmd_kind_e;

   typedef enum logic [2:0] {
      ST_IDLE, ST_IN_RUN, ST_IN_END, ST_OUT_RUN, ST_OUT_PAUSE, ST_OUT_END
   } burst_e;

   typedef struct packed {
      logic mode;
      logic strap;
      logic cs1_n;
      logic cs0_n;
      logic [2:0] addr;
      logic rd_n;
      logic wr_n;
      logic dmack_n;
      logic [15:0] data;
   } pins_s;

endpackage

//--- tb/ata_port_chk.sv
// Concurrent checks on the task-file and burst port.
// Assumes bind into the top module; bursts run with true_ide_mode high.
module ata_port_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic diow_n,
   input wire logic dd_oe_n,
   input wire logic dmarq,
   input wire logic iordy_out,
   input wire logic iordy_oe_n,
   input wire logic intrq,
   input wire logic dev_pos,
   input wire logic true_ide_mode,
   input wire logic sleep_mode,
   input wire logic [7:0] status_in,
   input wire logic irq_req,
   input wire logic udma_in_req,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_target,
   input wire logic soft_reset,
   input wire logic pio_rd_take,
   input wire logic burst_active
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Data-in strobe also rises, so only count it while the bus is not ours
   sequence seq_ready_drop;
      !iordy_oe_n && dd_oe_n && !udma_in_req && $rose(iordy_out);
   endsequence
   sequence seq_hold_request;
      (dmarq == true_ide_mode) [*3];
   endsequence
   chk_target_match: assert property (
      cmd_valid |-> cmd_target[ata_port_pkg::TARGET_DEV_BIT] == dev_pos)
      else $error("command taken for another device");
   chk_cmd_moment: assert property (
      cmd_valid |-> $past(diow_n, 2) && $past(da, 2) == ata_port_pkg::REG_FLAGS_OPCODE)
      else $error("command pulse without command write");
   chk_pause_wait: assert property (
      seq_ready_drop |=> seq_hold_request)
      else $error("request dropped too soon after ready");
   chk_bus_release: assert property (
      (dior_n && !burst_active) [*5] |-> dd_oe_n)
      else $error("data bus driven without read");
   chk_intrq_cause: assert property (
      intrq |-> $past(irq_req))
      else $error("interrupt without request");
   chk_srst_idle: assert property (
      soft_reset [*2] |-> !burst_active)
      else $error("burst running in soft reset");
   chk_request_level: assert property (
      (dmarq == true_ide_mode) |-> burst_active || $past(burst_active))
      else $error("request asserted while idle");
   chk_strobe_role: assert property (
      !iordy_oe_n |-> burst_active || $past(burst_active))
      else $error("ready line driven outside burst");
   chk_pio_gate: assert property (
      pio_rd_take |-> status_in[ata_port_pkg::FLAGS_DRQ_BIT] && !sleep_mode && !burst_active)
      else $error("data register read taken when barred");
endmodule

//--- tb/ata_host_model.sv
// Host controller model: register cycles and Ultra DMA bursts.
// Assumes true IDE polarity; paced by clk_sys, strobe edges 15 ns apart.
module ata_host_model (
   input wire logic clk_sys,
   input wire logic [15:0] dd_out,
   input wire logic dd_oe_n,
   input wire logic dmarq,
   input wire logic iordy_out,
   output logic cs0_n,
   output logic cs1_n,
   output logic [2:0] da,
   output logic dior_n,
   output logic diow_n,
   output logic dmack_n,
   output logic hstrobe_clk,
   output logic [15:0] dd_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] hd;
   // Released bus shows the inverse of the last host value
   assign dd_in = dd_oe_n ? hd : dd_out;
   initial begin
      {cs1_n, cs0_n, dior_n, diow_n, dmack_n} = 5'h1f;
      da = 3'h0;
      hstrobe_clk = 1'b0;
      hd = 16'hffff;
   end
   task automatic access(input logic [1:0] cs, input logic [2:0] a, input logic w,
         input logic [15:0] d, output logic [15:0] q);
      @(negedge clk_sys);
      {cs1_n, cs0_n} = cs;
      da = a;
      hd = w ? d : ~hd;
      diow_n = !w;
      dior_n = w;
      repeat (5) @(negedge clk_sys);
      q = dd_out;
      {dior_n, diow_n} = 2'h3;
      repeat (5) @(negedge clk_sys);
      {cs1_n, cs0_n} = 2'h3;
      hd = ~hd;
   endtask
   task automatic wait_dmarq(input logic lvl);
      for (int i = 0; i < 40 && dmarq !== lvl; i++) @(negedge clk_sys);
   endtask
   task automatic in_burst(output logic [15:0] q);
      wait_dmarq(1'b1);
      {dmack_n, diow_n, dior_n} = 3'h0;
      repeat (8) @(negedge clk_sys);
      q = dd_out;
      dior_n = 1'b1; // Late words after the pause are still fine
      repeat (ata_port_pkg::T_RP_CYC) @(negedge clk_sys);
      diow_n = 1'b1;
      wait_dmarq(1'b0);
      dmack_n = 1'b1;
   endtask
   task automatic out_burst(input logic [15:0] base, output int sent);
      sent = 0;
      wait_dmarq(1'b1);
      {dmack_n, diow_n} = 2'h0;
      for (int i = 0; i < 40 && iordy_out !== 1'b0; i++) @(negedge clk_sys);
      // Ready looked at per word; a late drop is covered by the three-word slack
      while (sent < 6 && iordy_out === 1'b0) begin
         hd = base + 16'(sent);
         #7;
         hstrobe_clk = ~hstrobe_clk;
         #8;
         sent++;
      end
      hd = ~hd;
      diow_n = 1'b1;
      wait_dmarq(1'b0);
      dmack_n = 1'b1;
   endtask
endmodule

//--- tb/test_ata_task_file_udma_port.sv
// Bench for the task-file and burst port: register cycles, commands, bursts.
// Assumes the host model drives the pins and the checker is bound below.
module test_ata_task_file_udma_port;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, ce, dev_pos, true_ide_mode, sleep_mode, irq_req;
   logic udma_in_req, din_valid, udma_out_req, cs0_n, cs1_n, dior_n, diow_n, dmack_n;
   logic hstrobe_clk, dd_oe_n, dmarq, iordy_out, iordy_oe_n, intrq, cmd_valid, soft_reset;
   logic pio_rd_take, pio_wr_valid, din_take, dout_valid, burst_active;
   logic [2:0] da;
   logic [7:0] status_in, fault_in, cmd_code, cmd_option, cmd_count, cmd_target;
   logic [15:0] pio_rd_word, din_word, dd_in, dd_out, pio_wr_word, dout_word, q, wr_seen;
   logic [23:0] cmd_lba;
   ata_port_pkg::cmd_kind_e cmd_kind;
   int mismatches, total_checks, cmd_cnt, n_got, sent;
   logic [15:0] got [16];
   logic [7:0] ops [10] = '{8'h98, 8'he5, 8'h90, 8'hc0, 8'h50, 8'hec, 8'h97, 8'he3, 8'h95, 8'he1};
   logic [2:0] kinds [10] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7};
   ata_task_file_udma_port DUT (.clk_sys, .rst, .ce, .hstrobe_clk, .cs0_n, .cs1_n, .da, .dior_n,
      .diow_n, .dmack_n, .dd_in, .dd_out, .dd_oe_n, .dmarq, .iordy_out, .iordy_oe_n, .intrq,
      .dev_pos, .true_ide_mode, .sleep_mode, .status_in, .fault_in, .irq_req, .cmd_valid,
      .cmd_code, .cmd_kind, .cmd_option, .cmd_count, .cmd_lba, .cmd_target, .soft_reset,
      .pio_rd_word, .pio_rd_take, .pio_wr_word, .pio_wr_valid, .udma_in_req, .din_word,
      .din_valid, .din_take, .udma_out_req, .dout_word, .dout_valid, .burst_active);
   ata_host_model host (.clk_sys, .dd_out, .dd_oe_n, .dmarq, .iordy_out, .cs0_n, .cs1_n,
      .da, .dior_n, .diow_n, .dmack_n, .hstrobe_clk, .dd_in);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [15:0] d);
      host.access(cs, a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [1:0] cs, input logic [2:0] a);
      host.access(cs, a, 1'b0, 16'h0000, q);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Pulses stand one cycle, so look at them between edges
   always @(negedge clk_sys) begin
      if (cmd_valid === 1'b1) cmd_cnt++;
      if (pio_wr_valid === 1'b1) wr_seen = pio_wr_word;
      if (dout_valid === 1'b1 && n_got < 16) begin
         got[n_got] = dout_word;
         n_got++;
      end
      if (din_take === 1'b1) din_valid = 1'b0;
      if (dmack_n === 1'b0 && diow_n === 1'b1) begin
         udma_in_req = 1'b0;
         udma_out_req = 1'b0;
      end
   end
   initial begin
      #400us;
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end
   initial begin
      {rst, ce, dev_pos, true_ide_mode, sleep_mode, irq_req} = 6'h3c;
      {udma_in_req, din_valid, udma_out_req} = 3'h0;
      {status_in, fault_in, pio_rd_word, din_word} = {8'h00, 8'h5e, 16'hbeef, 16'h5a3c};
      {mismatches, total_checks, cmd_cnt, n_got, wr_seen} = '0;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      check({22'h0, dmarq, dd_oe_n}, 24'h000001, "reset outputs");
      repeat (4) @(negedge clk_sys);
      for (int i = 1; i < 6; i++) wr(2'b10, 3'(i), 16'(i * 17));
      wr(2'b10, ata_port_pkg::REG_TARGET, 16'h0010);
      for (int i = 0; i < 10; i++) begin
         wr(2'b10, ata_port_pkg::REG_FLAGS_OPCODE, {8'h00, ops[i]});
         check({16'h0, cmd_code}, {16'h0, ops[i]}, "code");
         check({21'h0, cmd_kind}, {21'h0, kinds[i]}, "kind");
      end
      check(24'(cmd_cnt), 24'h00000a, "command pulses");
      check(cmd_lba, 24'h554433, "lba");
      check({cmd_option, cmd_count, cmd_target}, 24'h112210, "parameters");
      wr(2'b10, ata_port_pkg::REG_TARGET, 16'h0000);
      wr(2'b10, ata_port_pkg::REG_FLAGS_OPCODE, 16'h00ec);
      check(24'(cmd_cnt), 24'h00000a, "deselected command");
      wr(2'b10, ata_port_pkg::REG_TARGET, 16'h0010);
      $display("test commands done");
      status_in = 8'h01;
      rd(2'b10, ata_port_pkg::REG_FAULT_OPTION);
      check({8'h0, q}, 24'h00005e, "fault read");
      rd(2'b10, ata_port_pkg::REG_FLAGS_OPCODE);
      check({8'h0, q}, 24'h000001, "status");
      rd(2'b01, ata_port_pkg::REG_CONTROL);
      check({8'h0, q}, 24'h000001, "alternate status");
      rd(2'b10, ata_port_pkg::REG_LENGTH);
      check({8'h0, q}, 24'h000022, "length");
      rd(2'b10, ata_port_pkg::REG_DATA);
      check({8'h0, q}, 24'h000000, "data without drq");
      status_in = 8'h08;
      rd(2'b10, ata_port_pkg::REG_DATA);
      check({8'h0, q}, 24'h00beef, "data read");
      wr(2'b10, ata_port_pkg::REG_DATA, 16'hcafe);
      check({8'h0, wr_seen}, 24'h00cafe, "data write");
      sleep_mode = 1'b1;
      rd(2'b10, ata_port_pkg::REG_DATA);
      check({8'h0, q}, 24'h000000, "data in sleep");
      sleep_mode = 1'b0;
      $display("test reads done");
      irq_req = 1'b1;
      wr(2'b01, ata_port_pkg::REG_CONTROL, 16'h0000);
      check({23'h0, intrq}, 24'h000001, "interrupt on");
      wr(2'b01, ata_port_pkg::REG_CONTROL, 16'h0002);
      check({23'h0, intrq}, 24'h000000, "interrupt off");
      wr(2'b10, ata_port_pkg::REG_TARGET, 16'h0000);
      sleep_mode = 1'b1;
      wr(2'b01, ata_port_pkg::REG_CONTROL, 16'h0004);
      check({23'h0, soft_reset}, 24'h000001, "soft reset");
      wr(2'b01, ata_port_pkg::REG_CONTROL, 16'h0000);
      check({23'h0, soft_reset}, 24'h000000, "soft reset off");
      {sleep_mode, irq_req} = 2'h0;
      wr(2'b10, ata_port_pkg::REG_TARGET, 16'h0010);
      $display("test control done");
      {udma_in_req, din_valid} = 2'h3;
      host.in_burst(q);
      check({8'h0, q}, 24'h005a3c, "data-in word");
      repeat (5) @(negedge clk_sys);
      check({22'h0, din_valid, burst_active}, 24'h000000, "data-in end");
      $display("test data in done");
      udma_out_req = 1'b1;
      host.out_burst(16'h0a10, sent);
      repeat (12) @(negedge clk_sys);
      check({23'h0, sent > 0}, 24'h000001, "words sent");
      check(24'(n_got), 24'(sent), "words taken");
      for (int i = 0; i < n_got; i++) check({8'h0, got[i]}, 24'h000a10 + 24'(i), "word");
      check({23'h0, burst_active}, 24'h000000, "data-out end");
      $display("test data out done");
      end_sim();
   end
endmodule
bind ata_task_file_udma_port ata_port_chk u_chk (.clk_sys, .rst, .da, .dior_n, .diow_n,
   .dd_oe_n, .dmarq, .iordy_out, .iordy_oe_n, .intrq, .dev_pos, .true_ide_mode, .sleep_mode,
   .status_in, .irq_req, .udma_in_req, .cmd_valid, .cmd_target, .soft_reset, .pio_rd_take,
   .burst_active);
